// [nbm_pkg.sv]
// constants for the serial nonvolatile byte memory
package nbm_pkg;
    localparam int NBM_ADDR_W = 11;
    localparam int NBM_DEPTH = 2048;
    localparam int NBM_DATA_W = 8;
    localparam int NBM_CLK_HZ = 20_000_000;
    localparam logic [3:0] NBM_TYPE_CODE_DEF = 4'h5; // arbitrary value
    localparam logic [10:0] NBM_ADDR_ZERO = 11'h000;
    localparam logic [10:0] NBM_ADDR_ONE = 11'h001;
    localparam logic [3:0] NBM_BIT_LAST = 4'h7;
    localparam logic [3:0] NBM_BIT_ZERO = 4'h0;
    localparam logic [7:0] NBM_BYTE_ZERO = 8'h00;
    typedef enum logic [2:0] {
        NBM_IDLE = 3'b000,
        NBM_DEVADDR = 3'b001,
        NBM_WORDADDR = 3'b010,
        NBM_WRDATA = 3'b011,
        NBM_RDDATA = 3'b100,
        NBM_ACK = 3'b101,
        NBM_RDACK = 3'b110
    } nbm_state_t;
endpackage

// [nbm_target.sv]
// i2c target front end and 2k x 8 array
`timescale 1ns/1ns
module nbm_target
    import nbm_pkg::*;
#(
    parameter logic [3:0] TYPE_CODE = NBM_TYPE_CODE_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic wp
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] scl_sync_reg, scl_sync_next;
    logic [1:0] sda_sync_reg, sda_sync_next;
    logic [1:0] wp_sync_reg, wp_sync_next;
    logic scl_d_reg, scl_d_next;
    logic sda_d_reg, sda_d_next;
    logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

    always_comb begin
        scl_sync_next = {scl_sync_reg[0], scl_in};
        sda_sync_next = {sda_sync_reg[0], sda_in};
        wp_sync_next = {wp_sync_reg[0], wp};
        scl_s = scl_sync_reg[1];
        sda_s = sda_sync_reg[1];
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        scl_rise = scl_s && !scl_d_reg;
        scl_fall = !scl_s && scl_d_reg;
        start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            wp_sync_reg <= 2'b00;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
            wp_sync_reg <= wp_sync_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
        end
    end

    // ----------------------------------------
    // array
    // ----------------------------------------
    logic [NBM_DATA_W-1:0] mem [0:NBM_DEPTH-1];
    logic mem_we;
    logic [NBM_ADDR_W-1:0] mem_wa;
    logic [NBM_DATA_W-1:0] mem_wd;

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ----------------------------------------
    // protocol engine
    // ----------------------------------------
    nbm_state_t state_reg, state_next;
    nbm_state_t after_reg, after_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [NBM_ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] tx_reg, tx_next;
    logic drive_low_reg, drive_low_next;
    logic acked_reg, acked_next;
    logic [7:0] rx_byte;

    assign sda_out = 1'b0;
    assign sda_oe = drive_low_reg;

    always_comb begin
        state_next = state_reg;
        after_next = after_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        addr_next = addr_reg;
        tx_next = tx_reg;
        drive_low_next = drive_low_reg;
        acked_next = acked_reg;
        mem_we = 1'b0;
        mem_wa = addr_reg;
        mem_wd = shift_reg;
        rx_byte = {shift_reg[6:0], sda_s};
        if (start_c) begin
            state_next = NBM_DEVADDR;
            bit_next = NBM_BIT_ZERO;
            drive_low_next = 1'b0;
            acked_next = 1'b0;
        end else if (stop_c) begin
            state_next = NBM_IDLE;
            drive_low_next = 1'b0;
            acked_next = 1'b0;
        end else begin
            unique case (state_reg)
                NBM_IDLE: begin
                end
                NBM_DEVADDR, NBM_WORDADDR, NBM_WRDATA: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == NBM_BIT_LAST) begin
                            state_next = NBM_ACK;
                            after_next = NBM_IDLE;
                            if (state_reg == NBM_DEVADDR) begin
                                if (rx_byte[7:4] == TYPE_CODE) begin
                                    addr_next = {rx_byte[3:1], addr_reg[7:0]};
                                    after_next = rx_byte[0] ? NBM_RDDATA : NBM_WORDADDR;
                                end
                            end else if (state_reg == NBM_WORDADDR) begin
                                addr_next = {addr_reg[10:8], rx_byte};
                                after_next = NBM_WRDATA;
                            end else begin
                                mem_we = !wp_sync_reg[1];
                                mem_wd = rx_byte;
                                addr_next = addr_reg + NBM_ADDR_ONE;
                                after_next = NBM_WRDATA;
                            end
                        end
                    end
                end
                NBM_ACK: begin
                    if (scl_fall) begin
                        if (after_reg == NBM_IDLE) begin
                            state_next = NBM_IDLE;
                        end else if (!drive_low_reg) begin
                            drive_low_next = 1'b1;
                        end else begin
                            drive_low_next = 1'b0;
                            bit_next = NBM_BIT_ZERO;
                            state_next = after_reg;
                            if (after_reg == NBM_RDDATA) begin
                                tx_next = mem[addr_reg];
                                drive_low_next = !mem[addr_reg][7];
                            end
                        end
                    end
                end
                NBM_RDDATA: begin
                    if (scl_fall) begin
                        bit_next = bit_reg + 4'h1;
                        if (bit_reg == NBM_BIT_LAST) begin
                            drive_low_next = 1'b0; // release for ack
                            addr_next = addr_reg + NBM_ADDR_ONE;
                            state_next = NBM_RDACK;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            drive_low_next = !tx_reg[6];
                        end
                    end
                end
                NBM_RDACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_next = NBM_IDLE;
                        end else begin
                            acked_next = 1'b1;
                        end
                    end else if (scl_fall && acked_reg) begin
                        // controller acked: next byte goes out after this fall
                        acked_next = 1'b0;
                        bit_next = NBM_BIT_ZERO;
                        state_next = NBM_RDDATA;
                        tx_next = mem[addr_reg];
                        drive_low_next = !mem[addr_reg][7];
                    end
                end
                default: begin
                    state_next = NBM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= NBM_IDLE;
            after_reg <= NBM_IDLE;
            bit_reg <= NBM_BIT_ZERO;
            shift_reg <= NBM_BYTE_ZERO;
            addr_reg <= NBM_ADDR_ZERO;
            tx_reg <= NBM_BYTE_ZERO;
            drive_low_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            after_reg <= after_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            addr_reg <= addr_next;
            tx_reg <= tx_next;
            drive_low_reg <= drive_low_next;
            acked_reg <= acked_next;
        end
    end
endmodule

// [nbm_assertions.sv]
// pin checks for the serial byte memory
`timescale 1ns/1ns
module nbm_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic wp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_od; sda_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("sda driven high");
    property p_rst; $rose(rst_b) |-> !sda_oe [*3]; endproperty
    a_rst: assert property (p_rst) else $error("sda pulled after reset");
    property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
    a_edge: assert property (p_edge) else $error("sda moved with scl high");
    property p_hold; $rose(sda_oe) |=> $stable(sda_oe) [*3]; endproperty
    a_hold: assert property (p_hold) else $error("low pulse too short");
    property p_gap; $fell(sda_oe) |=> !sda_oe [*3]; endproperty
    a_gap: assert property (p_gap) else $error("release too short");
    property p_start; scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe [*4]; endproperty
    a_start: assert property (p_start) else $error("sda pulled after start");
    property p_stop; scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*4]; endproperty
    a_stop: assert property (p_stop) else $error("sda pulled after stop");
    property p_let; $rose(sda_oe) |-> ##[1:100] !sda_oe; endproperty
    a_let: assert property (p_let) else $error("sda never released");
endmodule

// [nbm_ctrl_model.sv]
// i2c controller model
`timescale 1ns/1ns
module nbm_ctrl_model (
    input wire logic clk,
    output logic scl,
    output logic m_pull,
    input wire logic sda
);
    initial scl = 1'b1;
    initial m_pull = 1'b0;
    // one scl period of 8 clocks, called at a rising clk edge
    // p2 differs from p1 only for start and stop
    task automatic ph(logic p1, logic p2, output logic q);
        scl <= 1'b0;
        repeat (2) @(posedge clk);
        m_pull <= p1;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        @(posedge clk);
        q = sda;
        m_pull <= p2;
        repeat (2) @(posedge clk);
    endtask
    task automatic x(logic [7:0] d, logic e, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) ph(!d[i], !d[i], q[i]);
        ph(!e, !e, a);
    endtask
endmodule

// [nbm_target_bench.sv]
// bench for the serial byte memory
`timescale 1ns/1ns
module nbm_target_bench
    import nbm_pkg::*;
;
    localparam logic [3:0] TC = 4'h9; // arbitrary value
    logic clk = 1'b0, rst_b = 1'b0, wp = 1'b0, scl, m_pull, dev_oe, a;
    wire logic sda = !(dev_oe || m_pull);
    logic [7:0] d, rm [NBM_DEPTH];
    int seed = 32'h5496_cd78, bad_count = 0, n_checks = 0, ra;
    initial forever #25 clk = !clk;
    nbm_target #(.TYPE_CODE(TC)) nbm_target_inst (.clk, .rst_b, .scl_in(scl),
        .sda_in(sda), .sda_out(), .sda_oe(dev_oe), .wp);
    nbm_ctrl_model bus (.clk, .scl, .m_pull, .sda);
    task chk_ack(logic e, logic s);
        n_checks++;
        if (s !== e) bad_count++;
        if (s !== e) $display("BAD ack bit exp %b got %b", e, s);
    endtask
    task chk_data(logic [7:0] e, logic [7:0] s);
        n_checks++;
        if (s !== e) bad_count++;
        if (s !== e) $display("BAD read byte exp %h got %h", e, s);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hw: send address and word address before data; ra follows the address latch
    task automatic op(logic [3:0] tc, logic [2:0] pg, logic [7:0] wd, int nw, int nr,
        logic w, logic hw);
        @(posedge clk) wp <= w;
        bus.ph(1'b0, 1'b1, a);
        if (hw) begin
            bus.x({tc, pg, 1'b0}, 1'b1, d, a);
            chk_ack(tc != TC, a);
            bus.x(wd, 1'b1, d, a);
            chk_ack(tc != TC, a);
            if (tc == TC) ra = {pg, wd};
        end
        for (int i = 0; i < nw; i++) begin
            bus.x(8'($random(seed)), 1'b1, d, a);
            chk_ack(1'b0, a);
            if (!w) rm[ra] = d;
            ra = (ra + 1) % NBM_DEPTH;
        end
        if (nr > 0 && hw) bus.ph(1'b0, 1'b1, a);
        if (nr > 0) begin
            bus.x({tc, pg, 1'b1}, 1'b1, d, a);
            chk_ack(tc != TC, a);
            ra = {pg, ra[7:0]};
        end
        for (int i = 1; i <= nr; i++) begin
            bus.x(8'hff, i == nr, d, a);
            chk_data(rm[ra], d);
            ra = (ra + 1) % NBM_DEPTH;
        end
        bus.ph(1'b1, 1'b0, a);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        op(TC, 3'h7, 8'hfe, 4, 0, 1'b0, 1'b1);
        op(TC, 3'h7, 8'hfe, 0, 4, 1'b0, 1'b1);
        op(TC, 3'h1, 8'h23, 3, 0, 1'b0, 1'b1);
        op(TC, 3'h1, 8'h23, 2, 0, 1'b1, 1'b1);
        op(TC, 3'h1, 8'h00, 0, 1, 1'b0, 1'b0);
        op(TC, 3'h1, 8'h23, 0, 2, 1'b0, 1'b1);
        op(4'h3, 3'h0, 8'h00, 0, 0, 1'b0, 1'b1);
        print_verdict;
    end
    initial begin
        #2_000_000 bad_count++;
        print_verdict;
    end
endmodule
bind nbm_target nbm_assertions nbm_assertions_inst (.clk, .rst_b, .scl_in, .sda_in,
    .sda_out, .sda_oe, .wp);
